// ==== err_signal.sv ====
// Purpose: decide which error message a detected error produces
// Assumes: error strobes are one-cycle pulses, synchronous to clk
// Notes: one message decision per cycle; message outputs are one-cycle pulses
`default_nettype none

// Summary of operation
// - severity per uncorrectable error is software programmable
// - without advanced reporting, severities stay fixed
// - class enables gate messages; system-error enable also passes non-fatal and fatal
// - separate per-error uncorrectable and correctable masks
// - disabled class never sends, regardless of masks
// - masked error sets status, no message, no log
// - physical error suppresses later packet errors
// - link-layer error suppresses later transaction errors
// - errors without packet always reported
// - one transaction error per packet by precedence
// - completion timeout reported outside precedence selection
// - advisory: correctable message with advanced reporting, else none
// - escalated fatal advisory error sends fatal message
// - fatal severity never gets advisory handling
// - completer unsupported or abort non-fatal is advisory
// - completer may poison data instead of aborting
// - forwarding receiver treats non-fatal packet error advisory
// - peer-to-peer root unable to forward sends non-fatal, drops
// - unexpected completion hides poison on same packet
module err_signal #(
    parameter bit HAS_AER = 1'b1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // per-packet error report: each layer flags its findings for one packet
    input wire logic pkt_valid,
    input wire logic pkt_phy_err,
    input wire logic pkt_dll_err,
    input wire logic [err_signal_pkg::UNC_WIDTH-1:0] pkt_tl_err,
    input wire logic pkt_forwarding,
    input wire logic pkt_p2p_no_prop,
    input wire logic pkt_completer_role,
    input wire logic pkt_poison_instead,
    // errors not tied to a packet
    input wire logic compl_timeout,
    input wire logic dll_protocol_err,
    input wire logic [err_signal_pkg::COR_WIDTH-1:0] cor_err,
    output logic msg_cor,
    output logic msg_nonfatal,
    output logic msg_fatal,
    output logic drop_packet
);
    localparam int unsigned NU = err_signal_pkg::UNC_ALL_WIDTH;
    localparam int unsigned NC = err_signal_pkg::COR_WIDTH;

    logic [err_signal_pkg::CTL_WIDTH-1:0] control_reg;
    logic [NU-1:0] severity_reg;
    logic [NU-1:0] unc_mask_reg;
    logic [NC-1:0] cor_mask_reg;
    logic [NU-1:0] unc_status_reg;
    logic [NC-1:0] cor_status_reg;
    logic [2:0] msg_seen_reg;
    logic [NU-1:0] unc_event;
    logic [NU-1:0] unc_report;
    logic [NU-1:0] sev_eff;
    logic [7:0] tl_sel;
    logic en_cor;
    logic en_nonfatal;
    logic en_fatal;
    logic want_cor;
    logic want_nonfatal;
    logic want_fatal;
    logic p2p_drop;

    // highest-precedence transaction error of one packet, one-hot
    function automatic logic [7:0] tl_pick(input logic [7:0] e);
        logic [7:0] r;
        r = 8'h00;
        if (e[err_signal_pkg::UNC_RX_OVERFLOW]) begin
            r[err_signal_pkg::UNC_RX_OVERFLOW] = 1'b1;
        end else if (e[err_signal_pkg::UNC_FC_PROTOCOL]) begin
            r[err_signal_pkg::UNC_FC_PROTOCOL] = 1'b1;
        end else if (e[err_signal_pkg::UNC_ECRC_FAIL]) begin
            r[err_signal_pkg::UNC_ECRC_FAIL] = 1'b1;
        end else if (e[err_signal_pkg::UNC_MALFORMED]) begin
            r[err_signal_pkg::UNC_MALFORMED] = 1'b1;
        end else if (e[err_signal_pkg::UNC_UNSUP_REQ]) begin
            r[err_signal_pkg::UNC_UNSUP_REQ] = 1'b1;
        end else if (e[err_signal_pkg::UNC_COMPL_ABORT]) begin
            r[err_signal_pkg::UNC_COMPL_ABORT] = 1'b1;
        end else if (e[err_signal_pkg::UNC_UNEXP_COMPL]) begin
            // keeps one pick even if the exclusive group arrives mixed; hides poison too
            r[err_signal_pkg::UNC_UNEXP_COMPL] = 1'b1;
        end else begin
            r[err_signal_pkg::UNC_POISONED] = e[err_signal_pkg::UNC_POISONED];
        end
        return r;
    endfunction

    // register writes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            control_reg <= err_signal_pkg::CONTROL_RESET;
            severity_reg <= err_signal_pkg::SEVERITY_RESET;
            unc_mask_reg <= err_signal_pkg::UNC_MASK_RESET;
            cor_mask_reg <= err_signal_pkg::COR_MASK_RESET;
        end else if (wr) begin
            case (addr)
                err_signal_pkg::OFS_CONTROL: control_reg <= wdata[err_signal_pkg::CTL_WIDTH-1:0];
                err_signal_pkg::OFS_SEVERITY: begin
                    if (HAS_AER) begin
                        severity_reg <= wdata[NU-1:0];
                    end
                end
                err_signal_pkg::OFS_UNC_MASK: begin
                    if (HAS_AER) begin
                        unc_mask_reg <= wdata[NU-1:0];
                    end
                end
                err_signal_pkg::OFS_COR_MASK: begin
                    if (HAS_AER) begin
                        cor_mask_reg <= wdata[NC-1:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // fixed severities without advanced reporting
    assign sev_eff = HAS_AER ? severity_reg : err_signal_pkg::SEVERITY_RESET;

    // layer suppression then transaction precedence
    always_comb begin
        unc_event = '0;
        tl_sel = 8'h00;
        if (pkt_valid && !pkt_phy_err && !pkt_dll_err) begin
            tl_sel = tl_pick(pkt_tl_err);
        end
        unc_event[7:0] = tl_sel;
        unc_event[err_signal_pkg::UNC_COMPL_TIMEOUT] = compl_timeout;
        // link protocol errors carry no packet, reported each time
        unc_event[err_signal_pkg::UNC_DLL_PROTOCOL] = dll_protocol_err;
    end

    // masked errors still land in status but never report
    assign unc_report = unc_event & ~unc_mask_reg;
    assign p2p_drop = pkt_p2p_no_prop && pkt_forwarding;

    // severity and role select class, enables gate sending
    always_comb begin
        want_cor = |(cor_err & ~cor_mask_reg);
        want_nonfatal = 1'b0;
        want_fatal = 1'b0;
        for (int i = 0; i < NU; i++) begin
            if (unc_report[i]) begin
                if (sev_eff[i]) begin
                    want_fatal = 1'b1;
                end else if (i < 8 && p2p_drop) begin
                    want_nonfatal = 1'b1;
                end else if (i < 8 && (pkt_forwarding
                             || (pkt_completer_role && !pkt_poison_instead
                                 && (i == err_signal_pkg::UNC_UNSUP_REQ
                                     || i == err_signal_pkg::UNC_COMPL_ABORT)))) begin
                    want_cor = want_cor | HAS_AER;
                end else begin
                    want_nonfatal = 1'b1;
                end
            end
        end
    end

    // class enables: device control bits, or system-error enable for non-fatal and fatal
    assign en_cor = control_reg[err_signal_pkg::CTL_COR_EN];
    assign en_nonfatal = control_reg[err_signal_pkg::CTL_NONFATAL_EN] | control_reg[err_signal_pkg::CTL_SERR_EN];
    assign en_fatal = control_reg[err_signal_pkg::CTL_FATAL_EN] | control_reg[err_signal_pkg::CTL_SERR_EN];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            msg_cor <= 1'b0;
            msg_nonfatal <= 1'b0;
            msg_fatal <= 1'b0;
            drop_packet <= 1'b0;
        end else begin
            msg_cor <= want_cor & en_cor;
            msg_nonfatal <= want_nonfatal & en_nonfatal;
            msg_fatal <= want_fatal & en_fatal;
            drop_packet <= pkt_valid & p2p_drop & (|pkt_tl_err);
        end
    end

    // sticky status, write one to clear, a new event wins over clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            unc_status_reg <= '0;
            cor_status_reg <= '0;
        end else begin
            unc_status_reg <= (unc_status_reg
                & ~((wr && addr == err_signal_pkg::OFS_UNC_STATUS) ? wdata[NU-1:0] : '0))
                | unc_event;
            cor_status_reg <= (cor_status_reg
                & ~((wr && addr == err_signal_pkg::OFS_COR_STATUS) ? wdata[NC-1:0] : '0))
                | cor_err;
        end
    end

    // record of messages sent, write one to clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            msg_seen_reg <= '0;
        end else begin
            msg_seen_reg <= (msg_seen_reg
                & ~((wr && addr == err_signal_pkg::OFS_MSG_STATUS) ? wdata[2:0] : 3'h0))
                | {msg_fatal, msg_nonfatal, msg_cor};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= '0;
        end else if (rd) begin
            case (addr)
                err_signal_pkg::OFS_CONTROL: rdata <= {28'h000_0000, control_reg};
                err_signal_pkg::OFS_SEVERITY: rdata <= {22'h00_0000, sev_eff};
                err_signal_pkg::OFS_UNC_MASK: rdata <= {22'h00_0000, unc_mask_reg};
                err_signal_pkg::OFS_COR_MASK: rdata <= {28'h000_0000, cor_mask_reg};
                err_signal_pkg::OFS_UNC_STATUS: rdata <= {22'h00_0000, unc_status_reg};
                err_signal_pkg::OFS_COR_STATUS: rdata <= {28'h000_0000, cor_status_reg};
                err_signal_pkg::OFS_MSG_STATUS: rdata <= {29'h0000_0000, msg_seen_reg};
                default: rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    masked_silent_a: assert property (@(posedge clk) disable iff (!resetn)
        (compl_timeout && unc_mask_reg[err_signal_pkg::UNC_COMPL_TIMEOUT] && cor_err == '0
         && !pkt_valid && !dll_protocol_err)
        |=> !msg_cor && !msg_nonfatal && !msg_fatal)
        else $error("masked error produced a message");

    masked_status_a: assert property (@(posedge clk) disable iff (!resetn)
        compl_timeout |=> unc_status_reg[err_signal_pkg::UNC_COMPL_TIMEOUT])
        else $error("status not set for detected error");

    class_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        !$past(en_fatal) |-> !msg_fatal)
        else $error("fatal message sent while disabled");

    phy_suppress_a: assert property (@(posedge clk) disable iff (!resetn)
        (pkt_valid && pkt_phy_err) |-> unc_event[7:0] == 8'h00)
        else $error("packet error reported after physical error");

    dll_suppress_a: assert property (@(posedge clk) disable iff (!resetn)
        (pkt_valid && pkt_dll_err) |-> tl_sel == 8'h00)
        else $error("transaction error reported after link error");

    one_per_pkt_a: assert property (@(posedge clk) disable iff (!resetn)
        $onehot0(tl_sel))
        else $error("more than one transaction error chosen");

    unexp_poison_a: assert property (@(posedge clk) disable iff (!resetn)
        (pkt_valid && pkt_tl_err[err_signal_pkg::UNC_UNEXP_COMPL]) |-> !tl_sel[err_signal_pkg::UNC_POISONED])
        else $error("poison reported beside unexpected completion");

    timeout_indep_a: assert property (@(posedge clk) disable iff (!resetn)
        compl_timeout |-> unc_event[err_signal_pkg::UNC_COMPL_TIMEOUT])
        else $error("completion timeout lost");

    fatal_sent_a: assert property (@(posedge clk) disable iff (!resetn)
        (compl_timeout && !unc_mask_reg[err_signal_pkg::UNC_COMPL_TIMEOUT]
         && sev_eff[err_signal_pkg::UNC_COMPL_TIMEOUT] && en_fatal) |=> msg_fatal)
        else $error("fatal error not signalled fatal");

    advisory_cor_a: assert property (@(posedge clk) disable iff (!resetn)
        (pkt_valid && pkt_forwarding && !pkt_p2p_no_prop && !pkt_phy_err && !pkt_dll_err
         && pkt_tl_err == 8'h80 && !unc_mask_reg[7] && !sev_eff[7] && !compl_timeout
         && !dll_protocol_err) |=> !msg_nonfatal && (msg_cor == (HAS_AER && $past(en_cor))))
        else $error("forwarded poison not advisory");

    cor_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        !$past(en_cor) |-> !msg_cor)
        else $error("correctable message sent while disabled");

    nonfatal_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        !$past(en_nonfatal) |-> !msg_nonfatal)
        else $error("non-fatal message sent while disabled");

    cor_report_a: assert property (@(posedge clk) disable iff (!resetn)
        ((cor_err & ~cor_mask_reg) != 4'h0 && en_cor) |=> msg_cor)
        else $error("unmasked correctable error not reported");

    cor_status_a: assert property (@(posedge clk) disable iff (!resetn)
        (cor_err != 4'h0) |=> (cor_status_reg & $past(cor_err)) == $past(cor_err))
        else $error("correctable status not set");

    sel_status_a: assert property (@(posedge clk) disable iff (!resetn)
        (tl_sel != 8'h00) |=> (unc_status_reg[7:0] & $past(tl_sel)) == $past(tl_sel))
        else $error("selected packet error not in status");

    masked_pkt_a: assert property (@(posedge clk) disable iff (!resetn)
        (tl_sel != 8'h00 && (tl_sel & ~unc_mask_reg[7:0]) == 8'h00 && !compl_timeout && !dll_protocol_err)
        |=> !msg_nonfatal && !msg_fatal)
        else $error("masked packet error produced a message");

    precedence_a: assert property (@(posedge clk) disable iff (!resetn)
        (pkt_valid && !pkt_phy_err && !pkt_dll_err && pkt_tl_err[err_signal_pkg::UNC_RX_OVERFLOW])
        |-> tl_sel == 8'h01)
        else $error("receiver overflow not chosen first");

    link_each_a: assert property (@(posedge clk) disable iff (!resetn)
        (dll_protocol_err && !unc_mask_reg[err_signal_pkg::UNC_DLL_PROTOCOL] && en_fatal && en_nonfatal)
        |=> msg_fatal || msg_nonfatal)
        else $error("link protocol error not reported");

    serr_fatal_a: assert property (@(posedge clk) disable iff (!resetn)
        (control_reg[err_signal_pkg::CTL_SERR_EN] && compl_timeout
         && !unc_mask_reg[err_signal_pkg::UNC_COMPL_TIMEOUT] && sev_eff[err_signal_pkg::UNC_COMPL_TIMEOUT])
        |=> msg_fatal)
        else $error("system-error enable did not pass fatal message");

    fatal_pkt_a: assert property (@(posedge clk) disable iff (!resetn)
        ((tl_sel & ~unc_mask_reg[7:0] & sev_eff[7:0]) != 8'h00 && en_fatal) |=> msg_fatal)
        else $error("fatal packet error not signalled fatal");

    escalate_a: assert property (@(posedge clk) disable iff (!resetn)
        (pkt_forwarding && (tl_sel & ~unc_mask_reg[7:0] & sev_eff[7:0]) != 8'h00 && en_fatal) |=> msg_fatal)
        else $error("escalated advisory error not fatal");

    completer_adv_a: assert property (@(posedge clk) disable iff (!resetn)
        (pkt_completer_role && !pkt_poison_instead && !pkt_p2p_no_prop && !compl_timeout && !dll_protocol_err
         && (tl_sel[5:4] & ~unc_mask_reg[5:4] & ~sev_eff[5:4]) != 2'b00) |=> !msg_nonfatal)
        else $error("completer abort reported non-fatal");

    poison_instead_a: assert property (@(posedge clk) disable iff (!resetn)
        (pkt_completer_role && pkt_poison_instead && !pkt_forwarding && en_nonfatal
         && (tl_sel[5:4] & ~unc_mask_reg[5:4] & ~sev_eff[5:4]) != 2'b00) |=> msg_nonfatal)
        else $error("poisoning completer not reported non-fatal");

    p2p_drop_a: assert property (@(posedge clk) disable iff (!resetn)
        (pkt_valid && pkt_forwarding && pkt_p2p_no_prop && pkt_tl_err != 8'h00) |=> drop_packet)
        else $error("peer-to-peer packet with error not dropped");

    p2p_msg_a: assert property (@(posedge clk) disable iff (!resetn)
        (pkt_forwarding && pkt_p2p_no_prop && (tl_sel & ~unc_mask_reg[7:0] & ~sev_eff[7:0]) != 8'h00
         && en_nonfatal) |=> msg_nonfatal)
        else $error("peer-to-peer error not reported non-fatal");
endmodule
`default_nettype wire

// ==== err_signal_pkg.sv ====
// Purpose: shared constants for the error message decision block
// Assumes: one core clock, asynchronous active-low reset
// Notes: error indices select bits of the severity, mask and status words
`default_nettype none
package err_signal_pkg;
    // uncorrectable error indices
    localparam int unsigned UNC_WIDTH = 8;
    localparam int unsigned UNC_RX_OVERFLOW = 0;
    localparam int unsigned UNC_FC_PROTOCOL = 1;
    localparam int unsigned UNC_ECRC_FAIL = 2;
    localparam int unsigned UNC_MALFORMED = 3;
    localparam int unsigned UNC_UNSUP_REQ = 4;
    localparam int unsigned UNC_COMPL_ABORT = 5;
    localparam int unsigned UNC_UNEXP_COMPL = 6;
    localparam int unsigned UNC_POISONED = 7;
    // additional uncorrectable errors outside packet selection
    localparam int unsigned UNC_COMPL_TIMEOUT = 8;
    localparam int unsigned UNC_DLL_PROTOCOL = 9;
    localparam int unsigned UNC_ALL_WIDTH = 10;
    localparam int unsigned COR_WIDTH = 4;
    // register offsets (word addresses)
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_SEVERITY = 4'h1;
    localparam logic [3:0] OFS_UNC_MASK = 4'h2;
    localparam logic [3:0] OFS_COR_MASK = 4'h3;
    localparam logic [3:0] OFS_UNC_STATUS = 4'h4;
    localparam logic [3:0] OFS_COR_STATUS = 4'h5;
    localparam logic [3:0] OFS_MSG_STATUS = 4'h6;
    // control register fields
    localparam int unsigned CTL_COR_EN = 0;
    localparam int unsigned CTL_NONFATAL_EN = 1;
    localparam int unsigned CTL_FATAL_EN = 2;
    localparam int unsigned CTL_SERR_EN = 3;
    localparam int unsigned CTL_WIDTH = 4;
    // reset values
    localparam logic [9:0] SEVERITY_RESET = 10'h0_210;
    localparam logic [9:0] UNC_MASK_RESET = 10'h0_000;
    localparam logic [3:0] COR_MASK_RESET = 4'h0;
    localparam logic [3:0] CONTROL_RESET = 4'h0;
    typedef enum logic [1:0] {
        MSG_NONE = 2'b00,
        MSG_COR = 2'b01,
        MSG_NONFATAL = 2'b11,
        MSG_FATAL = 2'b10
    } msg_class_type;
endpackage
`default_nettype wire

// ==== rc_msg_sink.sv ====
// Purpose: far-side model that takes in the non-fatal and fatal error messages the block sends
// Assumes: every message is a one-cycle pulse on clk
// Notes: keeps running totals so the bench can match them against its own tally
`default_nettype none
module rc_msg_sink (
    input wire logic clk,
    input wire logic resetn,
    input wire logic msg_nonfatal,
    input wire logic msg_fatal,
    output var int n_nonfatal,
    output var int n_fatal
);
    timeunit 1ns;
    timeprecision 1ps;
    // each pulse is one received message; merged causes arrive as one
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            n_nonfatal <= 0;
            n_fatal <= 0;
        end else begin
            n_nonfatal <= n_nonfatal + int'(msg_nonfatal);
            n_fatal <= n_fatal + int'(msg_fatal);
        end
    end
endmodule
`default_nettype wire

// ==== tb_error_message_signaling_control.sv ====
// Purpose: self-checking bench for the error message decision block
// Assumes: default advanced reporting build; xorshift stimulus from a fixed seed
// Notes: cor and drop outputs are only judged where their outcome is settled
`default_nettype none
module tb_error_message_signaling_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic msg_cor, msg_nonfatal, msg_fatal, drop_packet;
    logic v = 1'b0, ph = 1'b0, dl = 1'b0, fw = 1'b0, p2p = 1'b0, cp = 1'b0, pi = 1'b0, ct = 1'b0, dp = 1'b0;
    logic [7:0] tl = 8'h00;
    logic [3:0] ce = 4'h0, ctl_m = 4'h0, cm_m = 4'h0, exp_o = 4'h0, care_o = 4'h0;
    logic [9:0] sev_m = 10'h000, um_m = 10'h000;
    logic [31:0] seed = 32'h0000_8129;
    logic [31:0] a;
    int n_fail = 0, tests_run = 0, exp_f = 0, exp_n = 0, seen_f, seen_n;

    always #5 clk = ~clk;

    err_signal err_signal_i (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .pkt_valid(v), .pkt_phy_err(ph), .pkt_dll_err(dl), .pkt_tl_err(tl), .pkt_forwarding(fw),
        .pkt_p2p_no_prop(p2p), .pkt_completer_role(cp), .pkt_poison_instead(pi), .compl_timeout(ct),
        .dll_protocol_err(dp), .cor_err(ce), .msg_cor(msg_cor), .msg_nonfatal(msg_nonfatal),
        .msg_fatal(msg_fatal), .drop_packet(drop_packet));
    rc_msg_sink rc_msg_sink_i (.clk(clk), .resetn(resetn), .msg_nonfatal(msg_nonfatal),
        .msg_fatal(msg_fatal), .n_nonfatal(seen_n), .n_fatal(seen_f));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // packed stimulus: {ce, dp, ct, pi, cp, p2p, fw, tl, dl, ph, v}
    function automatic logic [20:0] rnd_stim();
        logic [31:0] x, y;
        x = rnd();
        y = rnd();
        return {x[3:0] & y[3:0], x[4] & y[4], x[5] & y[5], x[6], x[7] & ~x[9], x[8] & x[9], x[9],
            x[17:10] & y[17:10], x[18] & y[18] & x[19], x[20] & y[20] & x[21], x[22]};
    endfunction

    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_msg(input logic [3:0] e, input logic [3:0] g, input logic [3:0] care);
        tests_run++;
        if ((g & care) !== (e & care)) begin
            n_fail++;
            $display("BAD drop_fatal_nonfatal_cor expected %b seen %b", e & care, g);
        end
    endtask

    task automatic bus(input logic w, input logic r, input logic [3:0] ad, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= r;
        addr <= ad;
        wdata <= d;
    endtask

    task automatic wr_reg(input logic [3:0] ad, input logic [31:0] d);
        bus(1'b1, 1'b0, ad, d);
        bus(1'b0, 1'b0, 4'h0, 32'h0000_0000);
    endtask

    task automatic rd_chk(input string nm, input logic [3:0] ad, input logic [31:0] e);
        bus(1'b0, 1'b1, ad, 32'h0000_0000);
        bus(1'b0, 1'b0, 4'h0, 32'h0000_0000);
        #1 chk_reg(nm, e, rdata);
    endtask

    task automatic set_cfg(input logic [3:0] c, input logic [9:0] s, input logic [9:0] u, input logic [3:0] m);
        ctl_m = c;
        sev_m = s;
        um_m = u;
        cm_m = m;
        wr_reg(err_signal_pkg::OFS_CONTROL, {28'h000_0000, c});
        wr_reg(err_signal_pkg::OFS_SEVERITY, {22'h00_0000, s});
        wr_reg(err_signal_pkg::OFS_UNC_MASK, {22'h00_0000, u});
        wr_reg(err_signal_pkg::OFS_COR_MASK, {28'h000_0000, m});
    endtask

    // expected {drop, fatal, nonfatal, cor} for the inputs now applied
    task automatic predict();
        logic f, n, c, d;
        int s;
        f = 1'b0;
        n = 1'b0;
        d = 1'b0;
        s = -1;
        c = |(ce & ~cm_m);
        care_o = 4'h7;
        if (ph || dl) care_o[0] = 1'b0;
        if (v && !ph && !dl) for (int i = 7; i >= 0; i--) if (tl[i]) s = i;
        if (ct && !um_m[8]) begin f |= sev_m[8]; n |= !sev_m[8]; end
        if (dp && !um_m[9]) begin f |= sev_m[9]; n |= !sev_m[9]; end
        care_o[3] = (s >= 0) && !um_m[s] && !sev_m[s] && fw;
        if (s >= 0 && !um_m[s]) begin
            if (sev_m[s]) f = 1'b1;
            else if (fw && p2p) begin n = 1'b1; d = 1'b1; end
            else if (fw || (cp && !pi && (s == 4 || s == 5))) begin
                c = 1'b1;
                if (cm_m != 4'h0) care_o[0] = 1'b0;
            end else n = 1'b1;
        end
        exp_o = {d, f & (ctl_m[2] | ctl_m[3]), n & (ctl_m[1] | ctl_m[3]), c & ctl_m[0]};
        exp_f += int'(exp_o[2]);
        exp_n += int'(exp_o[1]);
    endtask

    task automatic step(input logic [20:0] x);
        @(posedge clk);
        {ce, dp, ct, pi, cp, p2p, fw, tl, dl, ph, v} <= x;
        #1 chk_msg(exp_o, {drop_packet, msg_fatal, msg_nonfatal, msg_cor}, care_o);
        predict();
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rd_chk("control", err_signal_pkg::OFS_CONTROL, 32'h0000_0000);
        rd_chk("severity", err_signal_pkg::OFS_SEVERITY, {22'h00_0000, err_signal_pkg::SEVERITY_RESET});
        rd_chk("unc_mask", err_signal_pkg::OFS_UNC_MASK, 32'h0000_0000);
        rd_chk("unmapped", 4'hF, 32'h0000_0000);
        $display("reset values done");
        set_cfg(4'h7, 10'h100, 10'h100, 4'h0);
        step(21'h0_8000);
        step(21'h2_0000);
        step(21'h0_0000);
        rd_chk("unc_status", err_signal_pkg::OFS_UNC_STATUS, 32'h0000_0100);
        wr_reg(err_signal_pkg::OFS_UNC_STATUS, 32'h0000_0100);
        rd_chk("unc_status_clr", err_signal_pkg::OFS_UNC_STATUS, 32'h0000_0000);
        rd_chk("cor_status", err_signal_pkg::OFS_COR_STATUS, 32'h0000_0001);
        $display("masked error done");
        set_cfg(4'hF, 10'h080, 10'h000, 4'h0);
        step(21'h0_0601);
        step(21'h0_0603);
        step(21'h0_0605);
        step(21'h0_0000);
        rd_chk("msg_status", err_signal_pkg::OFS_MSG_STATUS, 32'h0000_0003);
        wr_reg(err_signal_pkg::OFS_MSG_STATUS, 32'h0000_0007);
        rd_chk("msg_status_clr", err_signal_pkg::OFS_MSG_STATUS, 32'h0000_0000);
        $display("pollution cases done");
        for (int r = 0; r < 6; r++) begin
            a = rnd();
            set_cfg(r == 0 ? 4'hF : a[3:0], a[13:4], a[23:14] & a[31:22], a[27:24] & a[31:28]);
            rd_chk("severity_rw", err_signal_pkg::OFS_SEVERITY, {22'h00_0000, sev_m});
            rd_chk("unc_mask_rw", err_signal_pkg::OFS_UNC_MASK, {22'h00_0000, um_m});
            rd_chk("cor_mask_rw", err_signal_pkg::OFS_COR_MASK, {28'h000_0000, cm_m});
            repeat (40) step(rnd_stim());
            step(21'h0_0000);
            $display("random round %0d done", r);
        end
        repeat (2) @(posedge clk);
        #1;
        chk_reg("fatal_count", exp_f, seen_f);
        chk_reg("nonfatal_count", exp_n, seen_n);
        print_verdict();
    end

    initial begin
        #50000;
        n_fail++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule
`default_nettype wire
